// File: brs_pkg.sv
// How it works
// - leave lockout when supply above start
// - enter lockout and stop below stop threshold
// - overvoltage kills boost gate, holds one cycle
// - boost inhibited below lower minimum threshold
// - boost starts above upper minimum threshold
// - half-bridge waits for resonant-start level
// - half-bridge stops below resonant-stop level
// - boost switches before any half-bridge activity
// - half-bridge enable starts soft start
// - frequency limit blanks both half-bridge gates
// - blanking only on whole switching cycles
// - fast overcurrent shuts half-bridge at once
// - eight consecutive slow overcurrent cycles shut down
// - complementary equal 50 percent drive less dead
// - one dead-time setting for all gates
// - soft start pulls feedback to max frequency
// - after fault discharge, restart with soft start
// - boost overcurrent ends current boost pulse
// - boost edges avoid half-bridge switching edges, but not bridge start, stop or lockout edges
// - more feedback current gives higher frequency
package brs_pkg;

  // register offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LIMIT = 4'h4;
  localparam logic [3:0] ADDR_BOOST = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // reset values of the software registers
  localparam logic [7:0] DEAD_RESET = 8'h28;
  localparam logic [9:0] LIMIT_RESET = 10'h3e8;
  localparam logic [10:0] BOOST_ON_RESET = 11'h0c8;

  // timing: clock rate and nominal switching point
  localparam int CLK_MHZ = 200;
  localparam int NOM_KHZ = 100;
  localparam logic [10:0] HALF_NOM = 11'(CLK_MHZ * 1000 / NOM_KHZ / 2);
  localparam logic [10:0] MIN_ON = 11'h010;
  localparam logic [10:0] BOOST_OFFSET = 11'h008;
  // soft-start network discharge time in microseconds
  localparam int DISCHARGE_US = 100;
  localparam int DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;
  // soft start starts at reference-rail current and decays per cycle
  localparam logic [9:0] SS_TOP = 10'h3ff;
  localparam logic [9:0] SS_STEP = 10'h001;
  localparam logic [3:0] SLOW_LIMIT = 4'h8;

  // comparator flags from the analog front end
  typedef struct packed {
    logic supplyAboveStart;
    logic supplyBelowStop;
    logic overvoltage;
    logic minBoostUpper;
    logic minBoostLower;
    logic hbStartLevel;
    logic hbStopLevel;
    logic fastOvercurrent;
    logic slowOvercurrent;
    logic boostOvercurrent;
  } brs_flags_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } brs_bus_t;

  // the three gate drives
  typedef struct packed {
    logic boostGate;
    logic hbHighGate;
    logic hbLowGate;
  } brs_gates_t;

  // half-bridge sequencing states
  typedef enum logic [2:0] {
    HB_OFF = 3'b001,
    HB_RUN = 3'b010,
    HB_DISCHARGE = 3'b100
  } brs_hb_state_t;

endpackage

// File: brs_sequencer.sv
`timescale 1ns/1ps
module brs_sequencer #(
  parameter int DISCHARGE_CYCLES = brs_pkg::DISCHARGE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // comparator flags, raw
  input wire brs_pkg::brs_flags_t flagsIn,
  // resonant feedback current, digitised
  input wire logic [9:0] resonantFeedback,
  // register port
  input wire brs_pkg::brs_bus_t bus,
  output logic [31:0] rdata,
  // gate drives and soft-start pull-up
  output brs_pkg::brs_gates_t gates,
  output logic softStartPullup
);

  // whole state of the block
  typedef struct packed {
    brs_pkg::brs_flags_t syncA; // first synchroniser stage
    brs_pkg::brs_flags_t syncB; // second synchroniser stage
    logic [9:0] fbCur; // sampled feedback current
    logic [31:0] rdata; // read data register
    logic [7:0] deadTime; // shared dead time in clocks
    logic swEnable; // software run enable
    logic [9:0] limitCur; // max frequency current limit
    logic [10:0] boostOn; // boost on-time in clocks
    logic lockout; // supply lockout
    logic boostRun; // boost hysteresis state
    logic boostStarted; // boost has switched
    logic ovHold; // overvoltage hold-off
    logic ovAged; // one boundary seen since ov
    logic boostTerm; // boost pulse cut this cycle
    brs_pkg::brs_hb_state_t hbState; // half-bridge state
    logic softStart; // soft start active
    logic [9:0] ssLevel; // decaying soft-start current
    logic [10:0] cnt; // half-period counter
    logic phaseB; // second half of the cycle
    logic [10:0] halfPeriod; // current half period
    logic blank; // whole-cycle frequency blanking
    logic slowAll; // slow trip held all cycle
    logic [3:0] slowCount; // consecutive slow cycles
    logic [15:0] discharge; // discharge wait counter
    brs_pkg::brs_gates_t gates; // registered gate drives
  } brs_state_t;

  brs_state_t stateQ;
  brs_state_t stateD;

  // larger of two currents
  function automatic logic [9:0] maxCur(input logic [9:0] a, input logic [9:0] b);
    maxCur = (a > b) ? a : b;
  endfunction

  // half period from commanded current, never below dead plus minimum on
  function automatic logic [10:0] calcHalf(input logic [9:0] cmd, input logic [7:0] dead);
    logic [10:0] raw;
    logic [10:0] floorVal;
    raw = brs_pkg::HALF_NOM - {2'b00, cmd[9:1]};
    floorVal = {3'b000, dead} + brs_pkg::MIN_ON;
    calcHalf = (raw < floorVal) ? floorVal : raw;
  endfunction

  // next-state logic
  always_comb begin
    brs_pkg::brs_flags_t f;
    logic halfEnd;
    logic cycEnd;
    logic boostWin;
    logic [10:0] bStart;
    logic [10:0] bEnd;
    logic hbOn;
    f = stateQ.syncB;
    halfEnd = 1'b0;
    cycEnd = 1'b0;
    boostWin = 1'b0;
    bStart = '0;
    bEnd = '0;
    hbOn = 1'b0;
    stateD = stateQ;

    // two-flop synchronisers, feedback sample
    stateD.syncA = flagsIn;
    stateD.syncB = stateQ.syncA;
    stateD.fbCur = resonantFeedback;

    // register reads: data stand the next cycle only
    stateD.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        brs_pkg::ADDR_CTRL: begin
          stateD.rdata = {23'h0, stateQ.swEnable, stateQ.deadTime};
        end
        brs_pkg::ADDR_LIMIT: begin
          stateD.rdata = {22'h0, stateQ.limitCur};
        end
        brs_pkg::ADDR_BOOST: begin
          stateD.rdata = {21'h0, stateQ.boostOn};
        end
        brs_pkg::ADDR_STATUS: begin
          stateD.rdata = {20'h0, stateQ.slowCount, stateQ.hbState, stateQ.softStart,
                          stateQ.blank, stateQ.ovHold, stateQ.boostRun,
                          stateQ.lockout};
        end
        default: begin
          stateD.rdata = '0; // unmapped reads zero
        end
      endcase
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        brs_pkg::ADDR_CTRL: begin
          stateD.deadTime = bus.wdata[7:0];
          stateD.swEnable = bus.wdata[8];
        end
        brs_pkg::ADDR_LIMIT: begin
          stateD.limitCur = bus.wdata[9:0];
        end
        brs_pkg::ADDR_BOOST: begin
          stateD.boostOn = bus.wdata[10:0];
        end
        default: begin
          stateD.swEnable = stateQ.swEnable; // status and holes ignore writes
        end
      endcase
    end

    // supply lockout with start/stop hysteresis
    if (f.supplyBelowStop) begin
      stateD.lockout = 1'b1;
    end else if (f.supplyAboveStart) begin
      stateD.lockout = 1'b0;
    end

    // switching clock: two half periods per cycle
    halfEnd = (stateQ.cnt >= stateQ.halfPeriod - 11'h001);
    cycEnd = halfEnd && stateQ.phaseB;
    if (halfEnd) begin
      stateD.cnt = '0;
      stateD.phaseB = !stateQ.phaseB;
    end else begin
      stateD.cnt = stateQ.cnt + 11'h001;
    end

    // per-cycle updates on the cycle boundary
    if (cycEnd) begin
      // frequency follows the larger of feedback and soft-start current
      stateD.halfPeriod = calcHalf(maxCur(stateQ.fbCur, stateQ.ssLevel),
                                   stateQ.deadTime);
      // blanking decided for the whole next cycle
      stateD.blank = (stateQ.fbCur >= stateQ.limitCur);
      // soft-start current decays toward nominal
      if (stateQ.ssLevel > brs_pkg::SS_STEP) begin
        stateD.ssLevel = stateQ.ssLevel - brs_pkg::SS_STEP;
      end else begin
        stateD.ssLevel = '0;
        stateD.softStart = 1'b0;
      end
      stateD.boostTerm = 1'b0; // new pulse may start
    end

    // boost minimum-voltage hysteresis
    if (f.minBoostLower) begin
      stateD.boostRun = 1'b0;
    end else if (f.minBoostUpper) begin
      stateD.boostRun = 1'b1;
    end

    // overvoltage: off now, released after a full clean cycle
    if (f.overvoltage) begin
      stateD.ovHold = 1'b1;
      stateD.ovAged = 1'b0;
    end else if (cycEnd && stateQ.ovHold) begin
      if (stateQ.ovAged) begin
        stateD.ovHold = 1'b0;
      end
      stateD.ovAged = 1'b1;
    end

    // boost overcurrent cuts the pulse until the next cycle
    if (f.boostOvercurrent) begin
      stateD.boostTerm = 1'b1;
    end

    // boost window inside phase A, after the dead time, before phase end
    bStart = {3'b000, stateQ.deadTime} + brs_pkg::BOOST_OFFSET;
    bEnd = bStart + stateQ.boostOn;
    if (bEnd > stateQ.halfPeriod - 11'h001) begin
      bEnd = stateQ.halfPeriod - 11'h001;
    end
    boostWin = !stateQ.phaseB && (stateQ.cnt >= bStart) && (stateQ.cnt < bEnd);
    stateD.gates.boostGate = stateQ.swEnable && stateQ.boostRun && boostWin
                             && !f.overvoltage && !stateQ.ovHold
                             && !f.boostOvercurrent && !stateQ.boostTerm;
    if (stateD.gates.boostGate) begin
      stateD.boostStarted = 1'b1;
    end

    // slow overcurrent: trip must hold through a whole cycle
    if (!f.slowOvercurrent) begin
      stateD.slowAll = 1'b0;
    end
    if (cycEnd) begin
      stateD.slowAll = 1'b1;
    end

    // half-bridge sequencing
    unique case (stateQ.hbState)
      brs_pkg::HB_OFF: begin
        // boost first, then wait for the start level
        if (stateQ.swEnable && stateQ.boostStarted && f.hbStartLevel) begin
          stateD.hbState = brs_pkg::HB_RUN;
          stateD.softStart = 1'b1;
          stateD.ssLevel = brs_pkg::SS_TOP;
          stateD.slowCount = '0;
        end
      end
      brs_pkg::HB_RUN: begin
        if (f.fastOvercurrent) begin
          stateD.hbState = brs_pkg::HB_DISCHARGE;
          stateD.discharge = '0;
        end else if (cycEnd && stateQ.slowAll && f.slowOvercurrent
                     && (stateQ.slowCount + 4'h1 >= brs_pkg::SLOW_LIMIT)) begin
          stateD.hbState = brs_pkg::HB_DISCHARGE;
          stateD.discharge = '0;
        end else if (f.hbStopLevel || !stateQ.swEnable) begin
          stateD.hbState = brs_pkg::HB_OFF;
          stateD.softStart = 1'b0;
          stateD.ssLevel = '0;
        end
        // count whole tripped cycles; a clean cycle restarts the count
        if (cycEnd) begin
          if (stateQ.slowAll && f.slowOvercurrent) begin
            stateD.slowCount = stateQ.slowCount + 4'h1;
          end else begin
            stateD.slowCount = '0;
          end
        end
      end
      brs_pkg::HB_DISCHARGE: begin
        // soft-start network discharges before a fresh start
        stateD.softStart = 1'b0;
        stateD.ssLevel = '0;
        if (stateQ.discharge >= 16'(DISCHARGE_CYCLES - 1)) begin
          stateD.hbState = brs_pkg::HB_OFF;
        end else begin
          stateD.discharge = stateQ.discharge + 16'h0001;
        end
      end
      default: begin
        stateD.hbState = brs_pkg::HB_OFF; // illegal code recovers
      end
    endcase

    // complementary drive with equal on-times after the shared dead time
    hbOn = (stateQ.hbState == brs_pkg::HB_RUN) && !stateQ.blank
           && !f.fastOvercurrent && (stateQ.cnt >= {3'b000, stateQ.deadTime});
    stateD.gates.hbHighGate = hbOn && !stateQ.phaseB;
    stateD.gates.hbLowGate = hbOn && stateQ.phaseB;
    if (stateD.hbState != brs_pkg::HB_RUN) begin
      stateD.gates.hbHighGate = 1'b0;
      stateD.gates.hbLowGate = 1'b0;
    end

    // lockout holds every gate low and clears sequencing state
    if (stateQ.lockout) begin
      stateD.gates = '0;
      stateD.boostRun = 1'b0;
      stateD.boostStarted = 1'b0;
      stateD.boostTerm = 1'b0;
      stateD.ovHold = 1'b0;
      stateD.ovAged = 1'b0;
      stateD.hbState = brs_pkg::HB_OFF;
      stateD.softStart = 1'b0;
      stateD.ssLevel = '0;
      stateD.slowCount = '0;
      stateD.slowAll = 1'b1;
      stateD.discharge = '0;
      stateD.blank = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= '0;
      stateQ.deadTime <= brs_pkg::DEAD_RESET;
      stateQ.limitCur <= brs_pkg::LIMIT_RESET;
      stateQ.boostOn <= brs_pkg::BOOST_ON_RESET;
      stateQ.lockout <= 1'b1;
      stateQ.hbState <= brs_pkg::HB_OFF;
      stateQ.halfPeriod <= brs_pkg::HALF_NOM;
      stateQ.slowAll <= 1'b1;
    end else begin
      stateQ <= stateD;
    end
  end

  // outputs straight from the state register
  assign rdata = stateQ.rdata;
  assign gates = stateQ.gates;
  assign softStartPullup = stateQ.softStart;

endmodule

// File: brs_sequencer_monitor.sv
`timescale 1ns/1ps
module brs_sequencer_monitor #(
  parameter int DISCHARGE_CYCLES = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire brs_pkg::brs_flags_t flagsIn,
  input wire logic [9:0] resonantFeedback,
  input wire brs_pkg::brs_bus_t bus,
  input wire logic [31:0] rdata,
  input wire brs_pkg::brs_gates_t gates,
  input wire logic softStartPullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // limit copy, clocks spent at or over the limit, boost pulse seen
  logic [9:0] limQ;
  logic [12:0] overQ;
  logic seenQ;
  // helper state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limQ <= brs_pkg::LIMIT_RESET;
      overQ <= 13'h0;
      seenQ <= 1'b0;
    end else begin
      limQ <= (bus.wr && bus.addr == brs_pkg::ADDR_LIMIT) ? bus.wdata[9:0] : limQ;
      overQ <= (resonantFeedback < limQ) ? 13'h0 : overQ + 13'(overQ != 13'h1fff);
      seenQ <= seenQ | gates.boostGate;
    end
  end
  property p_no_overlap; !(gates.hbHighGate && gates.hbLowGate); endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
  property p_dead; $fell(gates.hbHighGate) |-> !gates.hbLowGate [*8]; endproperty
  a_dead: assert property (p_dead) else $error("no dead time");
  property p_edge; $rose(gates.boostGate) |-> $stable(gates[1:0]); endproperty
  a_edge: assert property (p_edge) else $error("boost edge meets bridge edge");
  property p_first; (gates.hbHighGate || gates.hbLowGate) |-> seenQ; endproperty
  a_first: assert property (p_first) else $error("bridge before boost");
  property p_lock; flagsIn.supplyBelowStop [*6] |-> gates == 3'h0; endproperty
  a_lock: assert property (p_lock) else $error("gates on in lockout");
  property p_ov; flagsIn.overvoltage [*5] |-> !gates.boostGate; endproperty
  a_ov: assert property (p_ov) else $error("boost on in overvoltage");
  property p_fast; flagsIn.fastOvercurrent [*5] |-> gates[1:0] == 2'h0; endproperty
  a_fast: assert property (p_fast) else $error("bridge on in overcurrent");
  property p_max_freq_setting; overQ > 13'h834 |-> gates[1:0] == 2'h0; endproperty
  a_max_freq_setting: assert property (p_max_freq_setting) else $error("bridge on over limit");
  c_run: cover property (gates.hbHighGate);
  c_soft: cover property ($rose(softStartPullup));
  c_blank: cover property (overQ > 13'h834);
endmodule
bind brs_sequencer brs_sequencer_monitor #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) mon (
  .clk(clk), .rst_n(rst_n), .flagsIn(flagsIn), .resonantFeedback(resonantFeedback),
  .bus(bus), .rdata(rdata), .gates(gates), .softStartPullup(softStartPullup));

// File: brs_plant.sv
`timescale 1ns/1ps
module brs_plant #(
  parameter logic [9:0] ON_LVL = 10'h258,
  parameter logic [9:0] LOW_LVL = 10'h1f4
) (
  // analog levels as codes
  input wire logic [9:0] supply,
  input wire logic [9:0] fb,
  input wire logic [9:0] resCur,
  input wire logic [9:0] boostCur,
  // comparator outputs
  output brs_pkg::brs_flags_t flags
);
  // plain comparators; bridge stop near 64 percent of a nominal 850
  assign flags = '{supply > ON_LVL, supply < 10'h190, fb > 10'h384, fb > ON_LVL, fb < LOW_LVL,
    fb > 10'h320, fb < 10'h220, resCur > 10'h320, resCur > LOW_LVL, boostCur > LOW_LVL};
endmodule

// File: brs_sequencer_tb_top.sv
`timescale 1ns/1ps
module brs_sequencer_tb_top;
  // clock, reset, analog levels, bus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] supply = 10'h000;
  logic [9:0] fb = 10'h000;
  logic [9:0] resCur = 10'h000;
  logic [9:0] boostCur = 10'h000;
  logic [9:0] fbCur = 10'h000;
  brs_pkg::brs_bus_t bus = '0;
  brs_pkg::brs_flags_t flags;
  brs_pkg::brs_gates_t gates;
  logic [31:0] rdata;
  logic [31:0] st;
  logic ss;
  int err_count = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  brs_plant plant (.supply(supply), .fb(fb), .resCur(resCur), .boostCur(boostCur), .flags(flags));
  brs_sequencer #(.DISCHARGE_CYCLES(50)) dut (.clk(clk), .rst_n(rst_n), .flagsIn(flags),
    .resonantFeedback(fbCur), .bus(bus), .rdata(rdata), .gates(gates), .softStartPullup(ss));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle bus strobes
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    st = rdata;
    @(posedge clk);
  endtask
  // bounded wait for one gate level
  task automatic waitG(input int i, input logic v, input int lim);
    while (gates[i] !== v && lim > 0) begin
      @(posedge clk);
      #1;
      lim--;
    end
    chk(32'(gates[i]), 32'(v));
    @(posedge clk);
  endtask
  // masked gates stay low for n clocks
  task automatic stayLow(input logic [2:0] m, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      bad = bad | ((gates & m) !== 3'h0);
    end
    chk(32'(bad), 32'h0);
    @(posedge clk);
  endtask
  // bounded wait for a bridge state code
  task automatic waitS(input logic [2:0] v, input int lim);
    rd(brs_pkg::ADDR_STATUS);
    while (st[7:5] !== v && lim > 0) begin
      rd(brs_pkg::ADDR_STATUS);
      lim--;
    end
    chk(32'(st[7:5]), 32'(v));
  endtask
  // reset values, unmapped read, lockout release
  task automatic t_regs;
    rd(brs_pkg::ADDR_CTRL);
    chk(st, 32'h28);
    // read data stand one cycle only, then drop to zero
    #1;
    chk(rdata, 32'h0);
    rd(brs_pkg::ADDR_LIMIT);
    chk(st, 32'h3e8);
    rd(4'h2);
    chk(st, 32'h0);
    rd(brs_pkg::ADDR_STATUS);
    chk(st & 32'hff1, 32'h21);
    supply <= 10'h384;
    repeat (6) @(posedge clk);
    rd(brs_pkg::ADDR_STATUS);
    chk(32'(st[0]), 32'h0);
  endtask
  // boost first; bridge only at start level, with soft start
  task automatic t_start;
    wr(brs_pkg::ADDR_CTRL, 32'h128);
    fb <= 10'h2bc;
    waitG(2, 1'b1, 4000);
    stayLow(3'h3, 3000);
    fb <= 10'h352;
    waitG(1, 1'b1, 3000);
    chk(32'(ss), 32'h1);
  endtask
  // feedback at limit blanks whole cycles
  task automatic t_max_freq_setting;
    fbCur <= 10'h3e8;
    repeat (2200) @(posedge clk);
    stayLow(3'h3, 2500);
    fbCur <= 10'h100;
    waitG(1, 1'b1, 3000);
  endtask
  // boost overcurrent ends the pulse
  task automatic t_boc;
    waitG(2, 1'b1, 4000);
    boostCur <= 10'h258;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(gates[2]), 32'h0);
    @(posedge clk);
    boostCur <= 10'h000;
  endtask
  // short overvoltage holds boost off a cycle
  task automatic t_ov;
    fb <= 10'h3c0;
    repeat (5) @(posedge clk);
    fb <= 10'h352;
    stayLow(3'h4, 900);
    waitG(2, 1'b1, 5000);
  endtask
  // fast and slow overcurrent, discharge, fresh soft start
  task automatic t_oc;
    resCur <= 10'h384;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(gates[1:0]), 32'h0);
    waitS(3'h4, 10);
    chk(32'(ss), 32'h0);
    resCur <= 10'h000;
    waitS(3'h2, 500);
    chk(32'(ss), 32'h1);
    resCur <= 10'h258;
    repeat (7) begin
      waitG(1, 1'b0, 3000);
      waitG(1, 1'b1, 3000);
    end
    rd(brs_pkg::ADDR_STATUS);
    chk(32'(st[7:5]), 32'h2);
    waitS(3'h4, 3500);
    resCur <= 10'h000;
    waitS(3'h2, 500);
  endtask
  // low feedback stops bridge and boost
  task automatic t_low;
    fb <= 10'h1c2;
    waitS(3'h1, 100);
    repeat (200) @(posedge clk);
    stayLow(3'h7, 2500);
    fb <= 10'h352;
    waitG(2, 1'b1, 5000);
  endtask
  // supply drop: lockout, then restart
  task automatic t_lock;
    supply <= 10'h12c;
    repeat (6) @(posedge clk);
    stayLow(3'h7, 10);
    rd(brs_pkg::ADDR_STATUS);
    chk(st & 32'hff1, 32'h21);
    supply <= 10'h384;
    wr(brs_pkg::ADDR_CTRL, 32'h128);
    waitG(2, 1'b1, 5000);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_start();
    t_max_freq_setting();
    t_boc();
    t_ov();
    t_oc();
    t_low();
    t_lock();
    final_report();
  end
  // hang guard
  initial begin
    #450000;
    err_count++;
    final_report();
  end
  task automatic final_report;
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule
